// ### pkg/fds_map.svh
// addresses, bit positions, codes and reset values of the data sequencer
`ifndef FDS_MAP_SVH
`define FDS_MAP_SVH
// ----------------------------------------------------------------
// engine register map (read channel = write channel + offset)
// ----------------------------------------------------------------
`define FDS_UOFF          16'h0100
`define FDS_U_STS         16'h0000
`define FDS_U_FNAME       16'h0004
`define FDS_U_FLEN        16'h0008
`define FDS_U_DT          16'h000C
`define FDS_U_CMD         16'h0010
`define FDS_U_FINFO       16'h0014
`define FDS_U_FSIZEL      16'h0018
`define FDS_U_FSIZEH      16'h001C
`define FDS_FNUM          16'h0020
`define FDS_FNUMCUR       16'h0024
`define FDS_TCP_STS       16'h0200
`define FDS_TCP_STS_ALIAS 16'h0204
`define FDS_TCP_PKL       16'h0208
`define FDS_TCP_TDL       16'h020C
`define FDS_TCP_CMD       16'h0210
`define FDS_TCP_TXD       16'h0214
`define FDS_TX_LEN        16'h0300
`define FDS_TX_BUF        16'h0400
// ----------------------------------------------------------------
// bits and command codes
// ----------------------------------------------------------------
`define FDS_BUSY_BIT      0
`define FDS_CONN_BIT      1
`define FDS_TXLEN_BUSY    31
`define FDS_TCP_SEND      32'h0000_0002
`define FDS_TCP_CLOSE     32'h0000_0003
`define FDS_U_WRITE       32'h0000_0001
`define FDS_U_READ        32'h0000_0002
`define FDS_ONE_FILE      32'h0000_0001
`define FDS_CHUNK_MAX     36'h0_8000_0000
// ----------------------------------------------------------------
// control replies, ascii
// ----------------------------------------------------------------
`define FDS_RP125         32'h3132_3520
`define FDS_RP226         32'h3232_3620
`define FDS_RP425         32'h3432_3520
`define FDS_RP_TAIL       32'h0D0A_0000
`define FDS_RP_LEN        32'h0000_0006
// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
`define FDS_SW_PKL        4'h0
`define FDS_SW_FTPDT      4'h4
`define FDS_SW_STATUS     4'h8
`define FDS_PKL_RST       32'h0000_2000
`define FDS_FTPDT_RST     32'h0000_0000
`endif

// ### pkg/fds_pkg.sv
// types of the data-connection command sequencer
package fds_pkg;
    typedef enum logic [1:0] {
        FDS_LIST = 2'h0,
        FDS_STOR = 2'h1,
        FDS_RETR = 2'h2
    } fds_cmd_e;

    typedef enum logic [4:0] {
        S_IDLE = 5'h00, S_CHK = 5'h01, S_LCNT = 5'h03, S_LNUM = 5'h02,
        S_LWDT = 5'h06, S_SNAME = 5'h07, S_SDT = 5'h05, S_SFLEN = 5'h04,
        S_SCMD = 5'h0C, S_CONN1 = 5'h0D, S_RPB = 5'h0F, S_RPW0 = 5'h0E,
        S_RPW1 = 5'h0A, S_RPLEN = 5'h0B, S_TPKL = 5'h09, S_TTDL = 5'h08,
        S_TSEND = 5'h18, S_LSEL = 5'h19, S_LINFO = 5'h1B, S_LTX0 = 5'h1A,
        S_LTX1 = 5'h1E, S_TBUSY = 5'h1F, S_TCLOSE = 5'h1D, S_TCBUSY = 5'h1C,
        S_WBUSY = 5'h14, S_CONN0 = 5'h15, S_RSZL = 5'h17, S_RSZH = 5'h16
    } fds_state_e;

    typedef struct packed {
        fds_cmd_e    code;
        logic [63:0] name;
    } fds_cmd_s;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
    } fds_ereq_s;
endpackage

// ### verilog/fds_sequencer.sv
// sequencer for ftp commands that use the data connection
`timescale 1ns/1ps
`include "fds_map.svh"

// Behaviour
// - store uses write channel zero
// - list and retrieve use read channel one
// - busy channel: reply 425, drop command
// - list count: stored, or in-progress while writing
// - wait connection bit one set before 125
// - program packet size, length, then send
// - list entries written into tcp data port
// - entry time: file info, or write datetime
// - send done when command busy bit clears
// - close connection, wait busy bit clear
// - reply 226 after data connection ends
// - ascii file name converted to index
// - store: name, datetime, then write command
// - file count fixed at one
// - store datetime from separate ftp setting
// - store ends when write channel idle
// - store waits connection closed before 226
// - retrieve: name then read command
// - read channel register = write plus offset
// - retrieve sends chunks of 2 GB max
// - counters cover files below 64 GB
// - reply waits free buffer, sets length
module fds_sequencer
    import fds_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    // decoded commands from the control parser
    input  wire logic        CMD_VALID,
    input  wire fds_cmd_s    CMD,
    output logic             CMD_READY,
    // engine register master
    output logic             EREG_VALID,
    output fds_ereq_s        EREG_REQ,
    input  wire logic        EREG_ACK,
    input  wire logic [31:0] EREG_RDATA,
    // axi4-lite slave, write
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [3:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic [1:0]       S_AXI_BRESP,
    // axi4-lite slave, read
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [3:0]  S_AXI_ARADDR,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fds_state_e  state;
    fds_state_e  rret;
    fds_cmd_e    code;
    logic [31:0] fidx;
    logic        wbusy;
    logic [31:0] nfiles;
    logic [31:0] wdt;
    logic [31:0] ts;
    logic [31:0] ent;
    logic [35:0] rem;
    logic [9:0]  rcode;
    logic [9:0]  last_rc;
    logic [31:0] sw_pkl;
    logic [31:0] sw_ftpdt;
    logic [15:0] choff;
    logic [35:0] chunk;
    logic [31:0] rp_word;

    // ascii decimal name to index, non-digits skipped
    function automatic logic [31:0] fds_name2idx(input logic [63:0] nm);
        logic [31:0] acc;
        logic [7:0]  c;
        acc = 32'h0000_0000;
        for (int i = 7; i >= 0; i--) begin
            c = nm[8*i +: 8];
            if (c >= 8'h30 && c <= 8'h39) begin
                acc = acc * 32'h0000_000A + {28'h000_0000, c[3:0]};
            end
        end
        return acc;
    endfunction

    assign choff = (code == FDS_STOR) ? 16'h0000 : `FDS_UOFF;
    // 2 GB cap per send; rem is wide enough for files below 64 GB
    assign chunk = (rem > `FDS_CHUNK_MAX) ? `FDS_CHUNK_MAX : rem;

    always_comb begin
        case (rcode)
            10'd125: rp_word = `FDS_RP125;
            10'd226: rp_word = `FDS_RP226;
            default: rp_word = `FDS_RP425;
        endcase
    end

    // ----------------------------------------------------------------
    // engine access for the current step
    // ----------------------------------------------------------------
    assign CMD_READY  = (state == S_IDLE);
    assign EREG_VALID = (state != S_IDLE);

    always_comb begin
        EREG_REQ = '0;
        case (state)
            S_CHK: begin
                EREG_REQ.addr = `FDS_U_STS + choff;
            end
            S_LCNT: begin
                EREG_REQ.addr = `FDS_U_STS;
            end
            S_LNUM: begin
                EREG_REQ.addr = wbusy ? `FDS_FNUMCUR : `FDS_FNUM;
            end
            S_LWDT: begin
                EREG_REQ.addr = `FDS_U_DT;
            end
            S_SNAME: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_U_FNAME + choff;
                EREG_REQ.wdata = fidx;
            end
            S_SDT: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_U_DT;
                EREG_REQ.wdata = sw_ftpdt;
            end
            S_SFLEN: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_U_FLEN + choff;
                EREG_REQ.wdata = `FDS_ONE_FILE;
            end
            S_SCMD: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_U_CMD + choff;
                EREG_REQ.wdata = (code == FDS_STOR) ? `FDS_U_WRITE
                                                    : `FDS_U_READ;
            end
            S_CONN1, S_CONN0: begin
                EREG_REQ.addr = (code == FDS_RETR) ? `FDS_TCP_STS_ALIAS
                                                   : `FDS_TCP_STS;
            end
            S_RPB: begin
                EREG_REQ.addr = `FDS_TX_LEN;
            end
            S_RPW0: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TX_BUF;
                EREG_REQ.wdata = rp_word;
            end
            S_RPW1: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TX_BUF + 16'h0004;
                EREG_REQ.wdata = `FDS_RP_TAIL;
            end
            S_RPLEN: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TX_LEN;
                EREG_REQ.wdata = `FDS_RP_LEN;
            end
            S_TPKL: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TCP_PKL;
                EREG_REQ.wdata = sw_pkl;
            end
            S_TTDL: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TCP_TDL;
                EREG_REQ.wdata = (code == FDS_LIST) ? {nfiles[28:0], 3'h0}
                                                    : chunk[31:0];
            end
            S_TSEND: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TCP_CMD;
                EREG_REQ.wdata = `FDS_TCP_SEND;
            end
            S_LSEL: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_U_FNAME + `FDS_UOFF;
                EREG_REQ.wdata = ent;
            end
            S_LINFO: begin
                EREG_REQ.addr = `FDS_U_FINFO + `FDS_UOFF;
            end
            S_LTX0: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TCP_TXD;
                EREG_REQ.wdata = ent;
            end
            S_LTX1: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TCP_TXD;
                EREG_REQ.wdata = ts;
            end
            S_TBUSY, S_TCBUSY: begin
                EREG_REQ.addr = `FDS_TCP_CMD;
            end
            S_TCLOSE: begin
                EREG_REQ.wr    = 1'b1;
                EREG_REQ.addr  = `FDS_TCP_CMD;
                EREG_REQ.wdata = `FDS_TCP_CLOSE;
            end
            S_WBUSY: begin
                EREG_REQ.addr = `FDS_U_STS;
            end
            S_RSZL: begin
                EREG_REQ.addr = `FDS_U_FSIZEL + `FDS_UOFF;
            end
            S_RSZH: begin
                EREG_REQ.addr = `FDS_U_FSIZEH + `FDS_UOFF;
            end
            default: EREG_REQ = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // step sequencer; steps move only on their engine ack, polling steps repeat until their bit matches
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state   <= S_IDLE;
            rret    <= S_IDLE;
            code    <= FDS_LIST;
            fidx    <= 32'h0000_0000;
            wbusy   <= 1'b0;
            nfiles  <= 32'h0000_0000;
            wdt     <= 32'h0000_0000;
            ts      <= 32'h0000_0000;
            ent     <= 32'h0000_0000;
            rem     <= 36'h0_0000_0000;
            rcode   <= 10'd0;
            last_rc <= 10'd0;
        end else if (state == S_IDLE) begin
            if (CMD_VALID) begin
                code  <= CMD.code;
                fidx  <= fds_name2idx(CMD.name);
                wbusy <= 1'b0;
                state <= S_CHK;
            end
        end else if (EREG_ACK) begin
            case (state)
                S_CHK: begin
                    if (EREG_RDATA[`FDS_BUSY_BIT]) begin
                        rcode <= 10'd425;
                        rret  <= S_IDLE;
                        state <= S_RPB;
                    end else if (code == FDS_LIST) begin
                        state <= S_LCNT;
                    end else begin
                        state <= S_SNAME;
                    end
                end
                S_LCNT: begin
                    wbusy <= EREG_RDATA[`FDS_BUSY_BIT];
                    state <= S_LNUM;
                end
                S_LNUM: begin
                    nfiles <= EREG_RDATA;
                    state  <= wbusy ? S_LWDT : S_CONN1;
                end
                S_LWDT: begin
                    wdt   <= EREG_RDATA;
                    state <= S_CONN1;
                end
                S_SNAME: begin
                    state <= (code == FDS_STOR) ? S_SDT : S_SFLEN;
                end
                S_SDT: begin
                    state <= S_SFLEN;
                end
                S_SFLEN: begin
                    state <= S_SCMD;
                end
                S_SCMD: begin
                    state <= S_CONN1;
                end
                S_CONN1: begin
                    if (EREG_RDATA[`FDS_CONN_BIT]) begin
                        rcode <= 10'd125;
                        state <= S_RPB;
                        case (code)
                            FDS_LIST: rret <= S_TPKL;
                            FDS_STOR: rret <= S_WBUSY;
                            default:  rret <= S_RSZL;
                        endcase
                    end
                end
                S_RPB: begin
                    // a reply may only start on a free tx buffer
                    if (!EREG_RDATA[`FDS_TXLEN_BUSY]) begin
                        state <= S_RPW0;
                    end
                end
                S_RPW0: begin
                    state <= S_RPW1;
                end
                S_RPW1: begin
                    state <= S_RPLEN;
                end
                S_RPLEN: begin
                    last_rc <= rcode;
                    state   <= rret;
                end
                S_TPKL: begin
                    state <= S_TTDL;
                end
                S_TTDL: begin
                    state <= S_TSEND;
                end
                S_TSEND: begin
                    ent <= 32'h0000_0000;
                    if (code == FDS_RETR) begin
                        rem <= rem - chunk;
                    end
                    state <= (code == FDS_LIST && nfiles != 32'h0000_0000)
                             ? S_LSEL : S_TBUSY;
                end
                S_LSEL: begin
                    state <= S_LINFO;
                end
                S_LINFO: begin
                    // the file still being written has no info yet
                    ts <= (wbusy && ent == nfiles - 32'h0000_0001)
                          ? wdt : EREG_RDATA;
                    state <= S_LTX0;
                end
                S_LTX0: begin
                    state <= S_LTX1;
                end
                S_LTX1: begin
                    ent   <= ent + 32'h0000_0001;
                    state <= (ent == nfiles - 32'h0000_0001)
                             ? S_TBUSY : S_LSEL;
                end
                S_TBUSY: begin
                    if (!EREG_RDATA[`FDS_BUSY_BIT]) begin
                        state <= (code == FDS_RETR &&
                                  rem != 36'h0_0000_0000) ? S_TPKL
                                                          : S_TCLOSE;
                    end
                end
                S_TCLOSE: begin
                    state <= S_TCBUSY;
                end
                S_TCBUSY: begin
                    if (!EREG_RDATA[`FDS_BUSY_BIT]) begin
                        rcode <= 10'd226;
                        rret  <= S_IDLE;
                        state <= S_RPB;
                    end
                end
                S_WBUSY: begin
                    if (!EREG_RDATA[`FDS_BUSY_BIT]) begin
                        state <= S_CONN0;
                    end
                end
                S_CONN0: begin
                    if (!EREG_RDATA[`FDS_CONN_BIT]) begin
                        rcode <= 10'd226;
                        rret  <= S_IDLE;
                        state <= S_RPB;
                    end
                end
                S_RSZL: begin
                    rem   <= {4'h0, EREG_RDATA};
                    state <= S_RSZH;
                end
                S_RSZH: begin
                    rem   <= {EREG_RDATA[3:0], rem[31:0]};
                    state <= S_TPKL;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave: write path
    // ----------------------------------------------------------------
    logic       aw_hold;
    logic       w_hold;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_hold && !S_AXI_BVALID;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            aw_addr      <= 4'h0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= 2'h0;
            sw_pkl       <= `FDS_PKL_RST;
            sw_ftpdt     <= `FDS_FTPDT_RST;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (aw_hold && w_hold) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= 2'h0;
                for (int b = 0; b < 4; b++) begin
                    if (w_strb[b] && aw_addr == `FDS_SW_PKL) begin
                        sw_pkl[8*b +: 8] <= w_data[8*b +: 8];
                    end
                    if (w_strb[b] && aw_addr == `FDS_SW_FTPDT) begin
                        sw_ftpdt[8*b +: 8] <= w_data[8*b +: 8];
                    end
                end
                // status is read-only; unmapped offsets answer slverr
                if (aw_addr != `FDS_SW_PKL && aw_addr != `FDS_SW_FTPDT) begin
                    S_AXI_BRESP <= 2'h2;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave: read path
    // ----------------------------------------------------------------
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= 2'h0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= 2'h0;
            case (S_AXI_ARADDR)
                `FDS_SW_PKL:    S_AXI_RDATA <= sw_pkl;
                `FDS_SW_FTPDT:  S_AXI_RDATA <= sw_ftpdt;
                `FDS_SW_STATUS: S_AXI_RDATA <= {6'h00, last_rc, 9'h000,
                                                code, state};
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= 2'h2;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

endmodule

// ### tb/fds_sequencer_sva.sv
// port checker of the data-connection sequencer
`timescale 1ns/1ps
`include "fds_map.svh"
module fds_sequencer_sva
    import fds_pkg::*;
(
    // clock, reset, command and engine ports
    input wire logic      CORE_CLK,
    input wire logic      RSTN,
    input wire logic      CMD_VALID,
    input wire fds_cmd_s  CMD,
    input wire logic      CMD_READY,
    input wire logic      EREG_VALID,
    input wire fds_ereq_s EREG_REQ,
    input wire logic      EREG_ACK
);
    // ------------------------------------------
    // engine write decode
    // ------------------------------------------
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    wire        w = EREG_VALID && EREG_REQ.wr;
    wire [15:0] a = EREG_REQ.addr;
    wire [31:0] d = EREG_REQ.wdata;
    property p_idle; CMD_READY |-> !EREG_VALID; endproperty
    a_idle: assert property (p_idle) else $error("idle access");
    property p_chan; CMD_VALID && CMD_READY |=> !CMD_READY && EREG_VALID
        && !EREG_REQ.wr && a == ($past(CMD.code) == FDS_STOR ?
        `FDS_U_STS : `FDS_UOFF); endproperty
    a_chan: assert property (p_chan) else $error("channel");
    // held payload keeps the programming order intact
    property p_hold; EREG_VALID && !EREG_ACK |=> EREG_VALID
        && $stable(EREG_REQ); endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_one; w && (a == `FDS_U_FLEN || a == `FDS_U_FLEN + `FDS_UOFF)
        |-> d == `FDS_ONE_FILE; endproperty
    a_one: assert property (p_one) else $error("file count");
    property p_chunk; w && a == `FDS_TCP_TDL |-> d <= 32'h8000_0000;
    endproperty
    a_chunk: assert property (p_chunk) else $error("chunk size");
    property p_len; w && a == `FDS_TX_LEN |-> d == `FDS_RP_LEN; endproperty
    a_len: assert property (p_len) else $error("reply length");
    property p_wcmd; w && a == `FDS_U_CMD |-> d == `FDS_U_WRITE; endproperty
    a_wcmd: assert property (p_wcmd) else $error("write cmd");
    property p_rcmd; w && a == `FDS_U_CMD + `FDS_UOFF |-> d == `FDS_U_READ;
    endproperty
    a_rcmd: assert property (p_rcmd) else $error("read cmd");
endmodule
bind fds_sequencer fds_sequencer_sva fds_sequencer_sva_i (.*);

// ### tb/fds_engine_model.sv
// tcp offload and storage engine registers, behavioural
`timescale 1ns/1ps
`include "fds_map.svh"
module fds_engine_model
    import fds_pkg::*;
(
    // clock, reset and engine register bus
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      valid,
    input  wire fds_ereq_s req,
    output logic           ack,
    output logic [31:0]    rdata
);
    logic [31:0] mem [1024];
    logic [35:0] sent;
    logic [3:0]  sends;
    logic [1:0]  cnt;
    logic        conn;
    wire  [9:0]  ix = req.addr[11:2];
    // odd words answer late; commands finish at once
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            foreach (mem[i]) mem[i] <= '0;
            {ack, cnt, sent, sends, rdata} <= '0;
            conn <= 1'b1;
        end else if (valid && !ack && cnt >= {1'b0, req.addr[2]}) begin
            ack <= 1'b1;
            cnt <= '0;
            rdata <= ix[9:1] == 9'h040 ? {30'h0, conn, 1'b0} : mem[ix];
            if (req.wr)
                mem[ix] <= ix == 10'h084 || ix == 10'h0C0 ? '0 : req.wdata;
            if (req.wr && ix == 10'h100)
                conn <= req.wdata != `FDS_RP125;
            if (req.wr && ix == 10'h083) begin
                sent <= sent + 36'(req.wdata);
                sends <= sends + 4'd1;
            end
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            cnt <= valid && !ack ? cnt + 2'd1 : 2'd0;
        end
    end
endmodule

// ### tb/fds_sequencer_bench.sv
// self-checking bench of the data-connection sequencer
`timescale 1ns/1ps
`include "fds_map.svh"
module fds_sequencer_bench;
    import fds_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
    typedef struct {fds_cmd_e c; logic b0, b1; logic [31:0] e [8];} fds_row_s;
    localparam logic [31:0] ok = `FDS_RP226, no = `FDS_RP425;
    localparam logic [31:0] dtw = 32'h1234_5678, dtf = 32'h5555_AAAA;
    localparam logic [31:0] ts = 32'h0A0B_0C0D;
    // words checked: reply, cmd0, cmd1, length, txdata, dt, name0, name1
    logic [15:0] ad [8] = '{16'h0400, 16'h0010, 16'h0110, 16'h020C,
        16'h0214, 16'h000C, 16'h0004, 16'h0104};
    fds_row_s rows [7];
    int bad_count = 0, samples_checked = 0;
    logic CORE_CLK = 0, RSTN = 0, CMD_VALID = 0, rdy, ev, ack, awr, wrr, arr;
    logic aw = 0, w = 0, ar = 0, bready = 0, rready = 0, bvalid, rvalid;
    logic [3:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, erd, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    fds_cmd_s CMD = '0;
    fds_ereq_s req;
    fds_sequencer fds_sequencer_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
        .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(rdy), .EREG_VALID(ev),
        .EREG_REQ(req), .EREG_ACK(ack), .EREG_RDATA(erd),
        .S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(w), .S_AXI_WREADY(wrr), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_BRESP(bresp), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));
    fds_engine_model eng (.clk(CORE_CLK), .rst_n(RSTN), .valid(ev),
        .req(req), .ack(ack), .rdata(erd));
    initial forever #50 CORE_CLK = ~CORE_CLK;
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        {aw, w, bready, awaddr, wdata} <= {3'b111, a, d};
        do begin
            @(posedge CORE_CLK);
            if (awr) aw <= 0;
            if (wrr) w <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        @(posedge CORE_CLK);
        {ar, rready, araddr} <= {2'b11, a};
        do begin
            @(posedge CORE_CLK);
            if (arr) ar <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0;
        {rd, resp} = {rdata, rresp};
    endtask
    task automatic run(input fds_row_s r);
        foreach (ad[k]) eng.mem[ad[k][11:2]] = '0;
        {eng.mem[0], eng.mem['h40], eng.mem[3]} = {31'h0,r.b0,31'h0,r.b1,dtw};
        @(posedge CORE_CLK);
        CMD <= '{r.c, "0000x017"}; // non-digits are skipped
        CMD_VALID <= 1;
        @(posedge CORE_CLK);
        CMD_VALID <= 0;
        do @(posedge CORE_CLK); while (rdy !== 1'b1);
        foreach (ad[k])
            `CHK(eng.mem[ad[k][11:2]], r.e[k])
    endtask
    task automatic final_report;
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rows[0] = '{FDS_STOR, 0, 0, '{ok, 1, 0, 0, 0, dtf, 17, 0}};
        rows[1] = '{FDS_RETR, 0, 0, '{ok, 0, 2, 16, 0, dtw, 0, 17}};
        rows[2] = '{FDS_LIST, 0, 0, '{ok, 0, 0, 16, ts, dtw, 0, 1}};
        rows[3] = '{FDS_LIST, 1, 0, '{ok, 0, 0, 24, dtw, dtw, 0, 2}};
        rows[4] = '{FDS_STOR, 1, 0, '{no, 0, 0, 0, 0, dtw, 0, 0}};
        rows[5] = '{FDS_RETR, 0, 1, '{no, 0, 0, 0, 0, dtw, 0, 0}};
        rows[6] = '{FDS_LIST, 0, 1, '{no, 0, 0, 0, 0, dtw, 0, 0}};
        repeat (8) @(posedge CORE_CLK);
        RSTN <= 1;
        @(posedge CORE_CLK);
        `CHK({rdy, ev}, 2'b10)
        axi_rd(4'h0);
        `CHK(rd, `FDS_PKL_RST)
        axi_wr(4'h4, dtf);
        `CHK(bresp, 2'b00)
        axi_rd(4'hC);
        `CHK(resp, 2'b10)
        // file size 4 GB + 16 forces three sends
        {eng.mem['h46], eng.mem['h47], eng.mem['h45]} = {32'h10, 32'h1, ts};
        {eng.mem[8], eng.mem[9]} = {32'h2, 32'h3};
        foreach (rows[i]) run(rows[i]);
        {eng.sent, eng.sends} = '0;
        run(rows[1]);
        `CHK({eng.sends, eng.sent}, {4'd3, 36'h1_0000_0010})
        axi_rd(4'h8);
        `CHK(rd[25:16], 10'd226)
        CMD <= '{FDS_STOR, "00000001"};
        CMD_VALID <= 1;
        @(posedge CORE_CLK);
        CMD_VALID <= 0;
        repeat (3) @(posedge CORE_CLK);
        RSTN <= 0;
        @(posedge CORE_CLK);
        `CHK({rdy, ev}, 2'b10)
        final_report;
    end
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        bad_count++;
        final_report;
    end
endmodule
